// ---- rtl/autoreload_pwm_outputs.sv ----
// Four-channel PWM generator on a shared 8-bit auto-reload counter, AXI4-Lite registers.
module autoreload_pwm_outputs
	import pwm_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	// Low power
	input  wire logic                 halt,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// AXI4-Lite read data
	output logic [DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Port pins
	input  wire logic [NUM_CH-1:0]    pwm_pin_in,
	output logic [NUM_CH-1:0]         pwm_output_pin,
	output logic [NUM_CH-1:0]         pwm_pin_oe_b
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [NUM_CH-1:0]            pwm_output_enable;
		logic [NUM_CH-1:0]            pwm_output_polarity;
		logic                         run;
		logic [CNT_W-1:0]             auto_reload_value;
		logic [NUM_CH-1:0][CNT_W-1:0] duty_compare_value;
		logic [15:0]                  presc;
		logic [NUM_CH-1:0]            port_dat;
		logic [NUM_CH-1:0]            port_dir;
		logic [CNT_W-1:0]             cnt;
		logic [NUM_CH-1:0]            pwm_lvl;
		logic [NUM_CH-1:0]            pin_out;
		logic [NUM_CH-1:0]            pin_oe_b;
		logic [NUM_CH-1:0]            sync1;
		logic [NUM_CH-1:0]            sync2;
		logic [NUM_CH-1:0]            sync3;
		logic [NUM_CH-1:0]            pin_seen;
		logic                         aw_got;
		logic [ADDR_W-1:0]            awaddr;
		logic                         w_got;
		logic [DATA_W-1:0]            wdata;
		logic [3:0]                   wstrb;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         rvalid;
		logic [1:0]                   rresp;
		logic [DATA_W-1:0]            rdata;
	} pwm_state_t;

	pwm_state_t s_q;
	pwm_state_t s_d;
	logic       tick;
	logic       tick_raw;

	// Counter clock enable, stopped in halt.
	pwm_tick_div u_div (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.run     (s_q.run && !halt),
		.divide  (s_q.presc),
		.tick    (tick_raw)
	);

	// A tick already registered in the divider must not slip through once halt rises.
	assign tick = tick_raw && !halt;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic              wr_go;
	logic [DATA_W-1:0] ctrl_rd;
	logic [DATA_W-1:0] wr_val;
	logic [NUM_CH-1:0] port_rd;
	logic [NUM_CH-1:0] cmp_hit;
	logic              ovf;

	assign ovf   = tick && (s_q.cnt == CNT_MAX);
	assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;

	assign ctrl_rd = {{(DATA_W-CTRL_RUN_BIT-1){1'b0}}, s_q.run,
		s_q.pwm_output_polarity, s_q.pwm_output_enable};

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			assign cmp_hit[g] = tick && (s_q.cnt == s_q.duty_compare_value[g]);
			// Input pins read PWM level when enabled, else the synchronised pin.
			assign port_rd[g] = s_q.port_dir[g] ? s_q.port_dat[g] :
				(s_q.pwm_output_enable[g] ? s_q.pwm_lvl[g] : s_q.pin_seen[g]);
		end
	endgenerate

	always_comb begin
		s_d    = s_q;
		wr_val = '0;
		// Three-stage pin synchroniser, change accepted when stages two and three agree.
		s_d.sync1 = pwm_pin_in;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
		for (int i = 0; i < NUM_CH; i++) begin
			if (s_q.sync2[i] == s_q.sync3[i]) begin
				s_d.pin_seen[i] = s_q.sync3[i];
			end
		end

		// Counter and waveform.
		if (tick) begin
			s_d.cnt = ovf ? s_q.auto_reload_value : s_q.cnt + 8'h01;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (ovf) begin
				s_d.pwm_lvl[i] = s_q.pwm_output_polarity[i];
			end else if (cmp_hit[i]) begin
				s_d.pwm_lvl[i] = ~s_q.pwm_output_polarity[i];
			end
		end

		// Pin drive: PWM overrides port settings.
		for (int i = 0; i < NUM_CH; i++) begin
			if (s_q.pwm_output_enable[i]) begin
				s_d.pin_out[i]  = s_d.pwm_lvl[i];
				s_d.pin_oe_b[i] = 1'b0;
			end else begin
				s_d.pin_out[i]  = s_q.port_dat[i];
				s_d.pin_oe_b[i] = ~s_q.port_dir[i];
			end
		end

		// AXI4-Lite write.
		if (s_axi_awvalid && !s_q.aw_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got && !s_q.bvalid) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (wr_go) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			case (s_q.awaddr)
				ADDR_CONTROL: begin
					wr_val = merge(ctrl_rd, s_q.wdata, s_q.wstrb);
					s_d.pwm_output_enable   = wr_val[CTRL_OE_LSB +: NUM_CH];
					s_d.pwm_output_polarity = wr_val[CTRL_POL_LSB +: NUM_CH];
					s_d.run                 = wr_val[CTRL_RUN_BIT];
				end
				ADDR_RELOAD: begin
					wr_val = merge({24'h00_0000, s_q.auto_reload_value}, s_q.wdata, s_q.wstrb);
					s_d.auto_reload_value = wr_val[CNT_W-1:0];
				end
				ADDR_CMP0, ADDR_CMP0 + 8'h04, ADDR_CMP0 + 8'h08, ADDR_CMP0 + 8'h0C: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (s_q.awaddr[ADDR_W-1:2] == ADDR_CMP0[ADDR_W-1:2] + 6'(i)) begin
							wr_val = merge({24'h00_0000, s_q.duty_compare_value[i]},
								s_q.wdata, s_q.wstrb);
							s_d.duty_compare_value[i] = wr_val[CNT_W-1:0];
						end
					end
				end
				ADDR_PORT: begin
					wr_val = merge({24'h00_0000, s_q.port_dir, s_q.port_dat},
						s_q.wdata, s_q.wstrb);
					s_d.port_dat = wr_val[NUM_CH-1:0];
					s_d.port_dir = wr_val[PORT_DIR_LSB +: NUM_CH];
				end
				ADDR_PRESC: begin
					wr_val = merge({16'h0000, s_q.presc}, s_q.wdata, s_q.wstrb);
					s_d.presc = wr_val[15:0];
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// AXI4-Lite read.
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			s_d.rdata  = '0;
			case (s_axi_araddr)
				ADDR_CONTROL: s_d.rdata = ctrl_rd;
				ADDR_RELOAD:  s_d.rdata[CNT_W-1:0] = s_q.auto_reload_value;
				ADDR_CMP0:    s_d.rdata[CNT_W-1:0] = s_q.duty_compare_value[0];
				ADDR_CMP0 + 8'h04: s_d.rdata[CNT_W-1:0] = s_q.duty_compare_value[1];
				ADDR_CMP0 + 8'h08: s_d.rdata[CNT_W-1:0] = s_q.duty_compare_value[2];
				ADDR_CMP0 + 8'h0C: s_d.rdata[CNT_W-1:0] = s_q.duty_compare_value[3];
				ADDR_CNT:     s_d.rdata[CNT_W-1:0] = s_q.cnt;
				ADDR_PORT:    s_d.rdata[2*NUM_CH-1:0] = {s_q.port_dir, port_rd};
				ADDR_PRESC:   s_d.rdata[15:0] = s_q.presc;
				default:      s_d.rresp = RESP_SLVERR;
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_q                    <= '0;
			s_q.auto_reload_value  <= RESET_RELOAD;
			s_q.duty_compare_value <= {NUM_CH{RESET_CMP}};
			s_q.presc              <= RESET_PRESC;
			s_q.pin_oe_b           <= {NUM_CH{1'b1}};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign s_axi_awready  = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready   = !s_q.w_got && !s_q.bvalid;
	assign s_axi_bvalid   = s_q.bvalid;
	assign s_axi_bresp    = s_q.bresp;
	assign s_axi_arready  = !s_q.rvalid;
	assign s_axi_rvalid   = s_q.rvalid;
	assign s_axi_rresp    = s_q.rresp;
	assign s_axi_rdata    = s_q.rdata;
	assign pwm_output_pin = s_q.pin_out;
	assign pwm_pin_oe_b   = s_q.pin_oe_b;

endmodule

// ---- rtl/pwm_pkg.sv ----
// Package of constants for the four-channel auto-reload PWM generator.
package pwm_pkg;

	localparam int unsigned NUM_CH       = 4;
	localparam int unsigned CNT_W        = 8;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned ADDR_W       = 8;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CMP0    = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CNT     = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_PORT    = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_PRESC   = 8'h20;

	// Field positions in the control register.
	localparam int unsigned CTRL_OE_LSB  = 0;
	localparam int unsigned CTRL_POL_LSB = 4;
	localparam int unsigned CTRL_RUN_BIT = 8;

	// Field positions in the port register: data in [3:0], direction in [7:4].
	localparam int unsigned PORT_DIR_LSB = 4;

	localparam logic [CNT_W-1:0]  CNT_MAX       = 8'hFF;
	localparam logic [CNT_W-1:0]  RESET_RELOAD  = 8'h00;
	localparam logic [CNT_W-1:0]  RESET_CMP     = 8'h00;
	localparam logic [15:0]       RESET_PRESC   = 16'h0000;
	localparam logic [1:0]        RESP_OKAY     = 2'b00;
	localparam logic [1:0]        RESP_SLVERR   = 2'b10;

endpackage

// ---- rtl/pwm_tick_div.sv ----
// Counter clock enable: divides the system clock into one-cycle pulses.
module pwm_tick_div
	import pwm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Control
	input  wire logic        run,
	input  wire logic [15:0] divide,
	// Enable pulse
	output logic             tick
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} div_state_t;

	div_state_t s_q;
	div_state_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (!run) begin
			s_d.cnt = 16'h0000;
		end else if (s_q.cnt >= divide) begin
			s_d.cnt  = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule

// ---- test/autoreload_pwm_outputs_sva.sv ----
// Bus handshake and halt checks on the PWM generator ports.
module autoreload_pwm_outputs_sva
	import pwm_pkg::*;
(
	// Clock, reset, low power
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire logic              halt,
	// Bus
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// Pins
	input wire logic [NUM_CH-1:0] pwm_output_pin
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_halted;
		halt [*4] ##0 !s_axi_bvalid;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("late bvalid");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("bresp dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late rvalid");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("rdata dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while busy");
	a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY
		|| s_axi_bresp == RESP_SLVERR) else $error("bad bresp");
	a_halt_freeze: assert property (s_halted |-> $stable(pwm_output_pin))
		else $error("pin moved in halt");
endmodule
bind autoreload_pwm_outputs autoreload_pwm_outputs_sva chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.halt(halt), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pwm_output_pin(pwm_output_pin));

// ---- test/autoreload_pwm_outputs_test.sv ----
// Register and waveform tests of the four-channel PWM generator.
module autoreload_pwm_outputs_test
	import pwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rst_b, halt, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, pin_in, pins, oe_b, ext, snap;
	logic [1:0] bresp, rresp;
	int n_fail, samples_checked, h;
	localparam logic [7:0] CMP [4] = '{8'hF1, 8'hF4, 8'hF8, 8'hFE};
	localparam int HI [4] = '{2, 11, 9, 15};
	autoreload_pwm_outputs dut (.clk_sys(clk_sys), .rst_b(rst_b), .halt(halt),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pwm_pin_in(pin_in), .pwm_output_pin(pins), .pwm_pin_oe_b(oe_b));
	pwm_load_model load (.drive_out(pins), .drive_oe_b(oe_b), .load_level(ext),
		.pin_level(pin_in));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk_sys);
		awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
		do @(negedge clk_sys); while (!(awready && wready));
		@(posedge clk_sys);
		awvalid <= 0; wvalid <= 0;
		do @(negedge clk_sys); while (bvalid !== 1'b1);
		chk("bresp", r, bresp);
		@(posedge clk_sys);
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk_sys);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(negedge clk_sys); while (arready !== 1'b1);
		@(posedge clk_sys);
		arvalid <= 0;
		do @(negedge clk_sys); while (rvalid !== 1'b1);
		chk("rdata", e, rdata);
		chk("rresp", r, rresp);
		@(posedge clk_sys);
		rready <= 0;
	endtask
	// Measures one period and its high time, from one rising edge to the next.
	task automatic meas(input int ch, input int e_hi);
		int n;
		logic p, v;
		n = 0; h = 0; v = 1;
		do @(negedge clk_sys); while (pins[ch] !== 1'b0);
		do @(negedge clk_sys); while (pins[ch] !== 1'b1);
		do begin
			if (v === 1'b1) h++;
			@(negedge clk_sys); n++; p = v; v = pins[ch];
		end while (!(v === 1'b1 && p === 1'b0));
		chk("period", 32'd16, 32'(n));
		chk("high", 32'(e_hi), 32'(h));
	endtask
	task automatic hold(input int ch, input int e);
		h = 0;
		repeat (300) begin
			@(negedge clk_sys);
			if (pins[ch] === 1'b1) h++;
		end
		chk("steady", 32'(e), 32'(h));
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		summarize();
	end
	initial begin
		rst_b = 0; halt = 0; awaddr = 0; awvalid = 0; wdata = 0; wstrb = 4'hF; wvalid = 0;
		bready = 0; araddr = 0; arvalid = 0; rready = 0; ext = 4'h6;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1;
		axi_rd(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
		axi_rd(ADDR_RELOAD, 32'h0000_0000, RESP_OKAY);
		axi_rd(ADDR_CMP0, 32'h0000_0000, RESP_OKAY);
		axi_rd(8'h40, 32'h0000_0000, RESP_SLVERR);
		axi_wr(ADDR_CNT, 32'h0000_0055, RESP_SLVERR);
		axi_wr(ADDR_PORT, 32'h0000_00F5, RESP_OKAY);
		axi_rd(ADDR_PORT, 32'h0000_00F5, RESP_OKAY);
		@(negedge clk_sys);
		chk("pins", 32'h5, 32'(pins));
		chk("oe_b", 32'h0, 32'(oe_b));
		$display("registers done");
		axi_wr(ADDR_RELOAD, 32'h0000_00F0, RESP_OKAY);
		axi_rd(ADDR_RELOAD, 32'h0000_00F0, RESP_OKAY);
		for (int i = 0; i < 4; i++) axi_wr(ADDR_CMP0 + 8'(4 * i), {24'h0, CMP[i]}, RESP_OKAY);
		axi_wr(ADDR_CONTROL, 32'h0000_01DF, RESP_OKAY);
		for (int i = 0; i < 4; i++) meas(i, HI[i]);
		$display("waveform done");
		@(posedge clk_sys);
		halt <= 1;
		repeat (5) @(negedge clk_sys);
		snap = pins;
		repeat (40) @(negedge clk_sys);
		chk("halted", 32'(snap), 32'(pins));
		@(posedge clk_sys);
		halt <= 0;
		$display("halt done");
		axi_wr(ADDR_PORT, 32'h0000_0000, RESP_OKAY);
		axi_wr(ADDR_RELOAD, 32'h0000_0000, RESP_OKAY);
		axi_wr(ADDR_CMP0 + 8'h0C, 32'h0000_00FF, RESP_OKAY);
		axi_wr(ADDR_CONTROL, 32'h0000_0188, RESP_OKAY);
		repeat (260) @(posedge clk_sys);
		hold(3, 300);
		chk("oe_b", 32'h7, 32'(oe_b));
		axi_rd(ADDR_PORT, 32'h0000_000E, RESP_OKAY);
		axi_wr(ADDR_CONTROL, 32'h0000_0108, RESP_OKAY);
		repeat (260) @(posedge clk_sys);
		hold(3, 0);
		axi_rd(ADDR_PORT, 32'h0000_0006, RESP_OKAY);
		axi_wr(ADDR_RELOAD, 32'h0000_00FA, RESP_OKAY);
		axi_wr(ADDR_CONTROL, 32'h0000_0144, RESP_OKAY);
		repeat (260) @(posedge clk_sys);
		hold(2, 300);
		$display("duty limits done");
		summarize();
	end
endmodule

// ---- test/pwm_load_model.sv ----
// External loads on the PWM pins, which drive a pin only while it is released.
module pwm_load_model
	import pwm_pkg::*;
(
	// Pin drive from the generator
	input  wire logic [NUM_CH-1:0] drive_out,
	input  wire logic [NUM_CH-1:0] drive_oe_b,
	// Load level and resolved pin
	input  wire logic [NUM_CH-1:0] load_level,
	output logic      [NUM_CH-1:0] pin_level
);
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			pin_level[i] = drive_oe_b[i] ? load_level[i] : drive_out[i];
		end
	end
endmodule
